// ---- pkg/cwt_pkg.sv ----
package cwt_pkg;
   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_GUARD = 8'h00;
   localparam logic [7:0] OFS_CLOCK = 8'h04;
   localparam logic [7:0] OFS_POWER = 8'h08;
   localparam logic [7:0] OFS_EXTIE = 8'h0C;
   localparam logic [7:0] OFS_GLOBIE = 8'h10;
   localparam logic [7:0] OFS_TACCESS = 8'h14;
   localparam logic [7:0] OFS_EVSTAT = 8'h18;
   localparam logic [7:0] OFS_EVMASK = 8'h1C;
   // field positions
   localparam int GC_RESTART_BIT = 0;
   localparam int GC_RSTEN_BIT = 1;
   localparam int GC_CAUSE_BIT = 2;
   localparam int GC_IRQF_BIT = 3;
   localparam int CK_SEL_LO_BIT = 6;
   localparam int CK_SEL_HI_BIT = 7;
   localparam int PM_MULT_BIT = 3;
   localparam int PM_DIV_LO_BIT = 6;
   localparam int PM_DIV_HI_BIT = 7;
   localparam int EIE_WDI_BIT = 4;
   localparam int IE_GLOBAL_BIT = 7;
   localparam int EV_TIMEOUT_BIT = 0;
   localparam int EV_WDRESET_BIT = 1;
   localparam int EV_W = 2;
   // reset values
   localparam logic [1:0] DIV_RST = 2'b10;
   localparam logic MULT_RST = 1'b0;
   localparam logic [1:0] SEL_RST = 2'b00;
   // timeout exponent bases per clock setting
   localparam logic [1:0] DIV_FAST = 2'b00;
   localparam logic [1:0] DIV_SLOW = 2'b11;
   localparam logic [5:0] BASE_X4 = 6'd15;
   localparam logic [5:0] BASE_X2 = 6'd16;
   localparam logic [5:0] BASE_MID = 6'd17;
   localparam logic [5:0] BASE_SLOW = 6'd25;
   localparam int CHAIN_W = 34;
   localparam int EXP_W = 6;
   // reset delay and cpu reset pulse
   localparam int DLY_W = 10;
   localparam logic [DLY_W-1:0] RST_DELAY_LAST = 10'h1FF;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CPU_RST_NS = 80;
   localparam logic [3:0] CPU_RST_CLKS = 4'(CPU_RST_NS / CLK_PERIOD_NS);
   localparam int TA_WINDOW_NS = 40;
   localparam logic [3:0] TA_WINDOW_CLKS = 4'(TA_WINDOW_NS / CLK_PERIOD_NS);
   // timed access keys
   localparam logic [7:0] TA_KEY1 = 8'hAA;
   localparam logic [7:0] TA_KEY2 = 8'h55;
   localparam logic [7:0] IRQ_VECTOR = 8'h63;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [23:0] PAD_ZERO = 24'h00_0000;
   // reset sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RST = 3'b100
   } cwt_seq_t;
endpackage : cwt_pkg

// ---- logic/cwt_chain.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwt_chain
   import cwt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic tick,
   input wire logic clear,
   input wire logic [EXP_W-1:0] expo,
   output logic fullCount
);
   typedef struct packed {
      logic [CHAIN_W-1:0] cnt;
      logic full;
   } cwt_chain_t;

   cwt_chain_t s_reg;
   cwt_chain_t s_next;
   logic [CHAIN_W-1:0] mask;

   ////////////////////////////////////////////////////////////////////
   // one mask bit per chain stage below the selected exponent
   genvar i;
   generate
      for (i = 0; i < CHAIN_W; i++) begin : g_mask
         assign mask[i] = (EXP_W'(i) < expo);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // free-running count, wraps after full count
   always_comb begin
      s_next = s_reg;
      s_next.full = 1'b0;
      if (clear) begin
         s_next.cnt = '0;
      end else if (tick) begin
         if (&(s_reg.cnt | ~mask)) begin
            s_next.cnt = '0;
            s_next.full = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + CHAIN_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_reg <= '0;
      end else if (clkEn) begin
         s_reg <= s_next;
      end
   end

   assign fullCount = s_reg.full;
endmodule : cwt_chain
`default_nettype wire

// ---- logic/cwt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwt_top
   import cwt_pkg::*;
#(
   parameter logic [EXP_W-1:0] EXP_TRIM = 6'd0
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic xtalTick,
   input wire logic sysReset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic cpuReset,
   output logic cpuIrqReq,
   output logic wakeReq,
   output logic [7:0] irqVector,
   output logic irqOut
);
   typedef struct packed {
      // bus slave
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [7:0] wData;
      logic wLane0;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [7:0] rData;
      logic [1:0] rResp;
      // control and status
      logic [1:0] timeoutSel;
      logic [1:0] sysClkDivider;
      logic clkMultiplierSel;
      logic timeoutIrqEnable;
      logic globalIrqEnable;
      logic timeoutResetEnable;
      logic timeoutIrqFlag;
      logic timeoutResetCauseFlag;
      // timed access
      logic taKey1Seen;
      logic [3:0] taWindow;
      // reset sequencer
      cwt_seq_t seq;
      logic [DLY_W-1:0] dly;
      logic [3:0] rstCnt;
      // events
      logic [EV_W-1:0] evStat;
      logic [EV_W-1:0] evMask;
      // registered outputs
      logic cpuReset;
      logic cpuIrqReq;
      logic wakeReq;
      logic irqOut;
   } cwt_state_t;

   localparam cwt_state_t S_RST = '{
      awHeld: 1'b0, awAddr: '0, wHeld: 1'b0, wData: '0, wLane0: 1'b0,
      bValid: 1'b0, bResp: RESP_OKAY, rValid: 1'b0, rData: '0, rResp: RESP_OKAY,
      timeoutSel: SEL_RST, sysClkDivider: DIV_RST, clkMultiplierSel: MULT_RST,
      timeoutIrqEnable: 1'b0, globalIrqEnable: 1'b0, timeoutResetEnable: 1'b0,
      timeoutIrqFlag: 1'b0, timeoutResetCauseFlag: 1'b0,
      taKey1Seen: 1'b0, taWindow: '0,
      seq: ST_IDLE, dly: '0, rstCnt: '0,
      evStat: '0, evMask: '0,
      cpuReset: 1'b0, cpuIrqReq: 1'b0, wakeReq: 1'b0, irqOut: 1'b0
   };

   cwt_state_t s_reg;
   cwt_state_t s_next;
   logic fullCount;
   logic chainClear;
   logic [EXP_W-1:0] expo;
   logic [EXP_W-1:0] base;
   logic [EXP_W-1:0] selTimes3;

   ////////////////////////////////////////////////////////////////////
   // timeout exponent from clock setting and select
   always_comb begin
      unique case (s_reg.sysClkDivider)
         DIV_FAST: base = s_reg.clkMultiplierSel ? BASE_X4 : BASE_X2;
         DIV_SLOW: base = BASE_SLOW;
         default: base = BASE_MID;
      endcase
   end

   // exponent is base plus three per select step, less EXP_TRIM
   assign selTimes3 = EXP_W'({s_reg.timeoutSel, 1'b0}) + EXP_W'(s_reg.timeoutSel);
   assign expo = base + selTimes3 - EXP_TRIM;

   ////////////////////////////////////////////////////////////////////
   // crystal counter chain
   cwt_chain u_chain (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .tick(xtalTick),
      .clear(chainClear),
      .expo(expo),
      .fullCount(fullCount)
   );

   ////////////////////////////////////////////////////////////////////
   // next-state logic: bus, timed access, flags, reset sequencer
   logic doWrite;
   logic restartHit;
   logic rstDone;
   logic taOpen;
   logic [7:0] rdByte;
   logic rdOk;
   logic keepCause;
   logic [EV_W-1:0] keepStat;
   logic [EV_W-1:0] keepMask;

   always_comb begin
      s_next = s_reg;
      restartHit = 1'b0;
      rstDone = 1'b0;
      rdByte = '0;
      rdOk = 1'b1;
      keepCause = 1'b0;
      keepStat = '0;
      keepMask = '0;
      taOpen = (s_reg.taWindow != '0);
      doWrite = s_reg.awHeld && s_reg.wHeld && !s_reg.bValid;

      // timed access window runs down by itself
      if (taOpen) begin
         s_next.taWindow = s_reg.taWindow - 4'(1);
      end

      // write address and data taken in either order
      if (s_axi_awvalid && !s_reg.awHeld) begin
         s_next.awHeld = 1'b1;
         s_next.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_reg.wHeld) begin
         s_next.wHeld = 1'b1;
         s_next.wData = s_axi_wdata[7:0];
         s_next.wLane0 = s_axi_wstrb[0];
      end

      // write decode once both halves are held
      if (doWrite) begin
         s_next.awHeld = 1'b0;
         s_next.wHeld = 1'b0;
         s_next.bValid = 1'b1;
         s_next.bResp = RESP_OKAY;
         if (s_reg.awAddr != OFS_TACCESS && s_reg.wLane0) begin
            s_next.taKey1Seen = 1'b0;
         end
         unique case (s_reg.awAddr)
            OFS_GUARD: begin
               if (s_reg.wLane0) begin
                  if (!s_reg.wData[GC_IRQF_BIT]) begin
                     s_next.timeoutIrqFlag = 1'b0;
                  end
                  if (!s_reg.wData[GC_CAUSE_BIT]) begin
                     s_next.timeoutResetCauseFlag = 1'b0;
                  end
                  if (taOpen) begin
                     s_next.timeoutResetEnable = s_reg.wData[GC_RSTEN_BIT];
                     restartHit = s_reg.wData[GC_RESTART_BIT];
                     s_next.taWindow = '0;
                  end
               end
            end
            OFS_CLOCK: begin
               if (s_reg.wLane0) begin
                  s_next.timeoutSel = {s_reg.wData[CK_SEL_HI_BIT], s_reg.wData[CK_SEL_LO_BIT]};
               end
            end
            OFS_POWER: begin
               if (s_reg.wLane0) begin
                  s_next.sysClkDivider = {s_reg.wData[PM_DIV_HI_BIT], s_reg.wData[PM_DIV_LO_BIT]};
                  s_next.clkMultiplierSel = s_reg.wData[PM_MULT_BIT];
               end
            end
            OFS_EXTIE: begin
               if (s_reg.wLane0) begin
                  s_next.timeoutIrqEnable = s_reg.wData[EIE_WDI_BIT];
               end
            end
            OFS_GLOBIE: begin
               if (s_reg.wLane0) begin
                  s_next.globalIrqEnable = s_reg.wData[IE_GLOBAL_BIT];
               end
            end
            OFS_TACCESS: begin
               if (s_reg.wLane0) begin
                  if (s_reg.wData == TA_KEY1) begin
                     s_next.taKey1Seen = 1'b1;
                  end else if (s_reg.taKey1Seen && s_reg.wData == TA_KEY2) begin
                     s_next.taKey1Seen = 1'b0;
                     s_next.taWindow = TA_WINDOW_CLKS;
                  end else begin
                     s_next.taKey1Seen = 1'b0;
                  end
               end
            end
            OFS_EVSTAT: begin
            end
            OFS_EVMASK: begin
               if (s_reg.wLane0) begin
                  s_next.evMask = s_reg.wData[EV_W-1:0];
               end
            end
            default: s_next.bResp = RESP_SLVERR;
         endcase
      end
      if (s_reg.bValid && s_axi_bready) begin
         s_next.bValid = 1'b0;
      end

      // read decode, one read under way at a time
      if (s_axi_arvalid && !s_reg.rValid) begin
         unique case (s_axi_araddr)
            OFS_GUARD: begin
               rdByte[GC_IRQF_BIT] = s_reg.timeoutIrqFlag;
               rdByte[GC_CAUSE_BIT] = s_reg.timeoutResetCauseFlag;
               rdByte[GC_RSTEN_BIT] = s_reg.timeoutResetEnable;
               rdByte[GC_RESTART_BIT] = 1'b0;
            end
            OFS_CLOCK: begin
               rdByte[CK_SEL_HI_BIT] = s_reg.timeoutSel[1];
               rdByte[CK_SEL_LO_BIT] = s_reg.timeoutSel[0];
            end
            OFS_POWER: begin
               rdByte[PM_DIV_HI_BIT] = s_reg.sysClkDivider[1];
               rdByte[PM_DIV_LO_BIT] = s_reg.sysClkDivider[0];
               rdByte[PM_MULT_BIT] = s_reg.clkMultiplierSel;
            end
            OFS_EXTIE: rdByte[EIE_WDI_BIT] = s_reg.timeoutIrqEnable;
            OFS_GLOBIE: rdByte[IE_GLOBAL_BIT] = s_reg.globalIrqEnable;
            OFS_TACCESS: rdByte = '0;
            OFS_EVSTAT: begin
               rdByte[EV_W-1:0] = s_reg.evStat;
               s_next.evStat = '0;
            end
            OFS_EVMASK: rdByte[EV_W-1:0] = s_reg.evMask;
            default: rdOk = 1'b0;
         endcase
         s_next.rValid = 1'b1;
         s_next.rData = rdByte;
         s_next.rResp = rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_reg.rValid && s_axi_rready) begin
         s_next.rValid = 1'b0;
      end

      // timeout sets flag; set wins over a clear in the same cycle
      if (fullCount) begin
         s_next.timeoutIrqFlag = 1'b1;
         s_next.evStat[EV_TIMEOUT_BIT] = 1'b1;
      end

      // reset sequencer: 512 clocks from flag to cpu reset
      unique case (s_reg.seq)
         ST_IDLE: begin
            if (fullCount && !restartHit) begin
               s_next.seq = ST_WAIT;
               s_next.dly = '0;
            end
         end
         ST_WAIT: begin
            s_next.dly = s_reg.dly + DLY_W'(1);
            if (restartHit) begin
               s_next.seq = ST_IDLE;
               s_next.dly = '0;
            end else if (s_reg.dly == RST_DELAY_LAST) begin
               if (s_reg.timeoutResetEnable) begin
                  s_next.seq = ST_RST;
                  s_next.rstCnt = CPU_RST_CLKS;
                  s_next.timeoutResetCauseFlag = 1'b1;
                  s_next.evStat[EV_WDRESET_BIT] = 1'b1;
               end else begin
                  s_next.seq = ST_IDLE;
               end
               s_next.dly = '0;
            end
         end
         ST_RST: begin
            s_next.rstCnt = s_reg.rstCnt - 4'(1);
            if (s_reg.rstCnt == 4'(1)) begin
               rstDone = 1'b1;
            end
         end
      endcase

      // cpu reset or system reset returns block to defaults, cause, event status and event mask kept
      if (rstDone || sysReset) begin
         keepCause = s_next.timeoutResetCauseFlag;
         keepStat = s_next.evStat;
         keepMask = s_next.evMask;
         s_next = S_RST;
         s_next.timeoutResetCauseFlag = keepCause;
         s_next.evStat = keepStat;
         s_next.evMask = keepMask;
      end

      // registered outputs follow the next state
      s_next.cpuReset = (s_next.seq == ST_RST);
      s_next.cpuIrqReq = s_next.timeoutIrqFlag && s_next.timeoutIrqEnable && s_next.globalIrqEnable;
      s_next.wakeReq = s_next.timeoutIrqFlag && s_next.timeoutIrqEnable;
      s_next.irqOut = |(s_next.evStat & s_next.evMask);
   end

   // restart clears the counter chain as well
   assign chainClear = restartHit || rstDone || sysReset;

   ////////////////////////////////////////////////////////////////////
   // state register, frozen while clock enable is low
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_reg <= S_RST;
      end else if (clkEn) begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from flops, except the fixed irq vector
   assign s_axi_awready = !s_reg.awHeld;
   assign s_axi_wready = !s_reg.wHeld;
   assign s_axi_bvalid = s_reg.bValid;
   assign s_axi_bresp = s_reg.bResp;
   assign s_axi_arready = !s_reg.rValid;
   assign s_axi_rvalid = s_reg.rValid;
   assign s_axi_rdata = {PAD_ZERO, s_reg.rData};
   assign s_axi_rresp = s_reg.rResp;
   assign cpuReset = s_reg.cpuReset;
   assign cpuIrqReq = s_reg.cpuIrqReq;
   assign wakeReq = s_reg.wakeReq;
   assign irqVector = IRQ_VECTOR;
   assign irqOut = s_reg.irqOut;
endmodule : cwt_top
`default_nettype wire

// ---- tb/cwt_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwt_properties
   import cwt_pkg::*;
#(
   parameter logic [EXP_W-1:0] EXP_TRIM = 6'd0
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cpuReset,
   input wire logic cpuIrqReq,
   input wire logic wakeReq,
   input wire logic [7:0] irqVector,
   input wire logic irqOut
);
   // one domain, reset disables everything but the reset check
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   // interrupt and reset outputs
   a_vector_fixed: assert property (irqVector == IRQ_VECTOR)
      else $error("irq vector not at service address");
   a_irq_needs_wake: assert property (cpuIrqReq |-> wakeReq)
      else $error("cpu irq without wake request");
   a_reset_pulse: assert property ($rose(cpuReset) |-> cpuReset [*8] ##1 !cpuReset)
      else $error("cpu reset pulse length wrong");
   a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=>
      !cpuReset && !cpuIrqReq && !wakeReq && !irqOut && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
   ////////////////////////////////////////////////////////////////////////////////
   // register bus timing, irq requests cleared by cpu reset
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
   a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address accepted");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not released after ready");
   a_reset_clears_irq: assert property ($fell(cpuReset) |-> !cpuIrqReq && !wakeReq)
      else $error("interrupt request survives cpu reset");
   // main scenarios
   c_cpu_reset: cover property ($rose(cpuReset));
   c_cpu_irq: cover property ($rose(cpuIrqReq));
   c_irq_out: cover property ($rose(irqOut));
   c_wake_only: cover property (wakeReq && !cpuIrqReq);
endmodule : cwt_properties
bind cwt_top cwt_properties #(.EXP_TRIM(EXP_TRIM)) u_cwt_properties (.*);
`default_nettype wire

// ---- tb/cpu_watchdog_timer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_watchdog_timer_test;
   import cwt_pkg::*;
   localparam logic [5:0] TRIM = 6'd12;
   logic ref_clk, reset_n, clkEn, xtalTick, sysReset, awValid, awReady, wValid, wReady, bValid, bReady;
   logic arValid, arReady, rValid, rReady, cpuReset, cpuIrqReq, wakeReq, irqOut;
   logic [7:0] awAddr, arAddr, irqVector;
   logic [31:0] wData, rData, d;
   logic [3:0] wStrb;
   logic [1:0] bResp, rResp, r, tickCnt;
   int errTotal = 0;
   int nCompared = 0;
   int cycles = 0;
   int n, m, e, expc;
   logic [7:0] pmrV [5] = '{8'h08, 8'h00, 8'h40, 8'h80, 8'hC0};
   logic [7:0] ckV [5] = '{8'hC0, 8'h80, 8'h00, 8'h40, 8'h00};
   logic [7:0] rstA [6] = '{OFS_GUARD, OFS_CLOCK, OFS_POWER, OFS_EXTIE, OFS_GLOBIE, OFS_EVMASK};
   logic [7:0] rstV [6] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
   cwt_top #(.EXP_TRIM(TRIM)) u_cwt_top (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
      .xtalTick(xtalTick), .sysReset(sysReset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .cpuReset(cpuReset),
      .cpuIrqReq(cpuIrqReq), .wakeReq(wakeReq), .irqVector(irqVector), .irqOut(irqOut));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, crystal tick every fourth cycle, hang guard
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      tickCnt <= tickCnt + 2'd1;
      xtalTick <= (tickCnt == 2'd3);
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         errTotal++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // checking and bus tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
      nCompared++;
      if (seen !== expv) begin
         errTotal++;
         $display("unexpected %s: expected %h seen %h", what, expv, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", errTotal, nCompared);
      if (errTotal == 0 && nCompared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   // bready held from the start so the timed window is not missed
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
      @(posedge ref_clk);
      awAddr <= a;
      wData <= {PAD_ZERO, v};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awReady === 1'b1) awValid <= 1'b0;
         if (wReady === 1'b1) wValid <= 1'b0;
      end while (bValid !== 1'b1);
      resp = bResp;
      bReady <= 1'b0;
   endtask : bus_wr
   // rready held from the start, answer taken at the edge where rvalid is seen
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge ref_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arReady === 1'b1) arValid <= 1'b0;
      end while (rValid !== 1'b1);
      v = rData;
      resp = rResp;
      rReady <= 1'b0;
   endtask : bus_rd
   task automatic ta_guard(input logic [7:0] v);
      logic [1:0] q;
      bus_wr(OFS_TACCESS, TA_KEY1, q);
      bus_wr(OFS_TACCESS, TA_KEY2, q);
      bus_wr(OFS_GUARD, v, q);
   endtask : ta_guard
   // cycles until a fresh rise of the wake request
   task automatic wait_wake(output int k);
      k = 0;
      while (wakeReq !== 1'b0 && k < 100) begin
         @(posedge ref_clk);
         k++;
      end
      while (wakeReq !== 1'b1 && k < 40000) begin
         @(posedge ref_clk);
         k++;
      end
   endtask : wait_wake
   task automatic watch(input int cyc, output int hits);
      hits = 0;
      repeat (cyc) begin
         @(posedge ref_clk);
         if (cpuReset === 1'b1) hits++;
      end
   endtask : watch
   function automatic int tb_base(input logic mult, input logic [1:0] div);
      if (div == 2'b00) return mult ? 15 : 16;
      if (div == 2'b11) return 25;
      return 17;
   endfunction : tb_base
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {reset_n, sysReset, awValid, wValid, bReady, arValid, rReady, xtalTick} = '0;
      clkEn = 1'b1;
      tickCnt = 2'd0;
      awAddr = 8'h00;
      arAddr = 8'h00;
      wData = 32'h0000_0000;
      wStrb = 4'h1;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         bus_rd(rstA[i], d, r);
         chk("reset value", d, {24'h00_0000, rstV[i]});
      end
      bus_rd(8'h20, d, r);
      chk("unmapped read resp", r, RESP_SLVERR);
      bus_wr(8'h24, 8'hFF, r);
      chk("unmapped write resp", r, RESP_SLVERR);
      bus_wr(OFS_GUARD, 8'h02, r);
      bus_rd(OFS_GUARD, d, r);
      chk("untimed enable write", d & 32'h0000_0002, 32'h0000_0000);
      bus_wr(OFS_EXTIE, 8'h10, r);
      for (int i = 0; i < 5; i++) begin
         bus_wr(OFS_POWER, pmrV[i], r);
         bus_wr(OFS_CLOCK, ckV[i], r);
         ta_guard(8'h01);
         wait_wake(n);
         e = tb_base(pmrV[i][3], pmrV[i][7:6]) + 3 * ckV[i][7:6] - TRIM;
         expc = 4 << e;
         chk("timeout cycles", 32'(n + 16 >= expc && n <= expc + 16), 32'd1);
         chk("cpu irq without global", 32'(cpuIrqReq), 32'd0);
         bus_rd(OFS_GUARD, d, r);
         chk("guard after timeout", d & 32'h0000_000B, 32'h0000_0008);
      end
      chk("irq out masked", 32'(irqOut), 32'd0);
      bus_wr(OFS_EVMASK, 8'h01, r);
      repeat (2) @(posedge ref_clk);
      chk("irq out unmasked", 32'(irqOut), 32'd1);
      bus_rd(OFS_EVSTAT, d, r);
      chk("event status", d, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      chk("irq out after clear", 32'(irqOut), 32'd0);
      bus_wr(OFS_GLOBIE, 8'h80, r);
      repeat (2) @(posedge ref_clk);
      chk("cpu irq with global", 32'(cpuIrqReq), 32'd1);
      chk("irq vector", 32'(irqVector), 32'h0000_0063);
      bus_wr(OFS_GLOBIE, 8'h00, r);
      bus_wr(OFS_POWER, 8'h80, r);
      bus_wr(OFS_CLOCK, 8'h40, r);
      // restart inside the delay cancels the pending reset
      ta_guard(8'h03);
      wait_wake(n);
      repeat (100) @(posedge ref_clk);
      ta_guard(8'h03);
      watch(700, m);
      chk("reset after restart", m, 32'd0);
      // dropping the enable inside the delay cancels it too
      wait_wake(n);
      ta_guard(8'h00);
      watch(600, m);
      chk("reset after disable", m, 32'd0);
      // clock enable low for 20 cycles freezes the delay count
      ta_guard(8'h03);
      wait_wake(n);
      clkEn <= 1'b0;
      repeat (20) @(posedge ref_clk);
      clkEn <= 1'b1;
      m = 20;
      while (cpuReset !== 1'b1 && m < 1000) begin
         @(posedge ref_clk);
         m++;
      end
      chk("reset delay", m, 32'd532);
      repeat (12) @(posedge ref_clk);
      bus_rd(OFS_GUARD, d, r);
      chk("cause flag", d & 32'h0000_0007, 32'h0000_0004);
      bus_rd(OFS_CLOCK, d, r);
      chk("select after reset", d, 32'h0000_0000);
      bus_rd(OFS_EVSTAT, d, r);
      chk("reset event", d & 32'h0000_0002, 32'h0000_0002);
      sysReset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sysReset <= 1'b0;
      bus_rd(OFS_GUARD, d, r);
      chk("cause kept", d & 32'h0000_0004, 32'h0000_0004);
      tally_and_finish();
   end
endmodule : cpu_watchdog_timer_test
`default_nettype wire
